/* File: dac_ctrl_pkg.sv */
// Package with register map, field positions and reset values of the dual converter control block.
package dac_ctrl_pkg;

    // ------------------------------------------------------------
    // Register addresses in the special-function-register space
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CH0_LOW = 8'hf9;
    localparam logic [7:0] ADDR_CH0_HIGH = 8'hfa;
    localparam logic [7:0] ADDR_CH1_LOW = 8'hfb;
    localparam logic [7:0] ADDR_CH1_HIGH = 8'hfc;
    localparam logic [7:0] ADDR_CONTROL = 8'hfd;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h04;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // ------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------
    localparam int BIT_WIDTH_SEL = 7;
    localparam int BIT_SPAN_CH1 = 6;
    localparam int BIT_SPAN_CH0 = 5;
    localparam int BIT_ZERO_N_CH1 = 4;
    localparam int BIT_ZERO_N_CH0 = 3;
    localparam int BIT_SYNC = 2;
    localparam int BIT_POWER_CH1 = 1;
    localparam int BIT_POWER_CH0 = 0;

    localparam int CODE_W = 12;
    localparam int HIGH_NIBBLE_W = 4;
    localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;

    // Update handling of one channel.
    typedef enum logic [1:0] {
        UPD_IDLE = 2'b00,
        UPD_LOAD = 2'b01,
        UPD_HELD = 2'b11
    } update_state_t;

    // Forms the 12-bit code from the two data bytes in the selected width.
    function automatic logic [CODE_W-1:0] form_code(input logic eight_bit, input logic [7:0] low_b,
                                                   input logic [7:0] high_b);
        if (eight_bit) begin
            form_code = {low_b, 4'h0};
        end else begin
            form_code = {high_b[HIGH_NIBBLE_W-1:0], low_b};
        end
    endfunction

endpackage

/* File: dac_byte_reg.sv */
// One 8-bit software data byte register with write strobe.
module dac_byte_reg (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Write side
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // Stored value
    output logic [7:0] value_q
);
    import dac_ctrl_pkg::*;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            value_q <= DATA_RESET;
        end else if (wr_en) begin
            value_q <= wr_data;
        end
    end

endmodule

/* File: dac_channel_update.sv */
// Output code holding latch of one converter channel with immediate and held update.
module dac_channel_update (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Triggers
    input wire logic low_written,
    input wire logic sync_rise,
    input wire logic sync_mode,
    // Code to load
    input wire logic [dac_ctrl_pkg::CODE_W-1:0] next_code,
    // Applied code and state
    output logic [dac_ctrl_pkg::CODE_W-1:0] code_q,
    output logic pending
);
    import dac_ctrl_pkg::*;

    update_state_t state_q;
    update_state_t state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            UPD_IDLE: begin
                if (low_written) begin
                    state_d = sync_mode ? UPD_LOAD : UPD_HELD;
                end
            end
            UPD_LOAD: begin
                state_d = UPD_IDLE;
            end
            UPD_HELD: begin
                if (sync_rise) begin
                    state_d = UPD_LOAD;
                end
            end
            default: begin
                state_d = UPD_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= UPD_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Immediate mode loads in the cycle after the low byte write; held mode waits for sync to rise.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            code_q <= CODE_ZERO;
        end else if ((low_written && sync_mode) || sync_rise) begin // see RQ7 see RQ8
            code_q <= next_code;
        end
    end

    assign pending = (state_q == UPD_HELD);

endmodule

/* File: dual_dac_register_control.sv */
// Register file and output control for two 12-bit voltage output converters.
//
// Behaviour
// RQ1: Immediate 12-bit mode updates on low byte write.
// RQ2: Bit 7 picks 8-bit or 12-bit width.
// RQ3: Bit 6 picks channel 1 span.
// RQ4: Bit 5 picks channel 0 span.
// RQ5: Bits 4,3 low force outputs to zero.
// RQ6: Bits 1,0 power channels on or off.
// RQ7: Bit 2 high updates on low write.
// RQ8: Bit 2 low holds; rising edge updates both.
// RQ9: Software writes codes right-justified across bytes.
// RQ10: Control resets to 04H, channels off.
// RQ11: All four data bytes reset to 00H.
// RQ12: Disabled channel drives output enable inactive.
// RQ13: 8-bit mode ignores high byte; same timing.
module dual_dac_register_control
    import dac_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Special-function-register access from the core
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_sel,
    // Converter channel 0
    output logic [dac_ctrl_pkg::CODE_W-1:0] ch0_code,
    output logic span_select_ch0,
    output logic ch0_output_enable,
    output logic ch0_power,
    // Converter channel 1
    output logic [dac_ctrl_pkg::CODE_W-1:0] ch1_code,
    output logic span_select_ch1,
    output logic ch1_output_enable,
    output logic ch1_power,
    // Status
    output logic ch0_pending,
    output logic ch1_pending
);
    import dac_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic wr_ctrl;
    logic wr_l0;
    logic wr_h0;
    logic wr_l1;
    logic wr_h1;
    logic hit;

    assign wr_ctrl = sfr_wr && (sfr_addr == ADDR_CONTROL);
    assign wr_l0 = sfr_wr && (sfr_addr == ADDR_CH0_LOW);
    assign wr_h0 = sfr_wr && (sfr_addr == ADDR_CH0_HIGH);
    assign wr_l1 = sfr_wr && (sfr_addr == ADDR_CH1_LOW);
    assign wr_h1 = sfr_wr && (sfr_addr == ADDR_CH1_HIGH);
    assign hit = (sfr_addr >= ADDR_CH0_LOW) && (sfr_addr <= ADDR_CONTROL);
    assign sfr_sel = hit;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic [7:0] converter_output_control_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            converter_output_control_q <= CONTROL_RESET; // see RQ10
        end else if (wr_ctrl) begin
            converter_output_control_q <= sfr_wdata;
        end
    end

    logic eight_bit_mode;
    logic sync_mode;
    logic zero_force_n_ch0;
    logic zero_force_n_ch1;
    logic power_on_ch0;
    logic power_on_ch1;

    assign eight_bit_mode = converter_output_control_q[BIT_WIDTH_SEL]; // see RQ2
    assign sync_mode = converter_output_control_q[BIT_SYNC];
    assign zero_force_n_ch0 = converter_output_control_q[BIT_ZERO_N_CH0];
    assign zero_force_n_ch1 = converter_output_control_q[BIT_ZERO_N_CH1];
    assign power_on_ch0 = converter_output_control_q[BIT_POWER_CH0];
    assign power_on_ch1 = converter_output_control_q[BIT_POWER_CH1];

    // A write that sets the sync bit from 0 releases the held codes of both channels together.
    logic sync_rise;
    assign sync_rise = wr_ctrl && !sync_mode && sfr_wdata[BIT_SYNC]; // see RQ8

    // ------------------------------------------------------------
    // Data byte registers
    // ------------------------------------------------------------
    logic [7:0] channel0_low_byte;
    logic [7:0] channel0_high_byte;
    logic [7:0] channel1_low_byte;
    logic [7:0] channel1_high_byte;

    // All four bytes come up as zero.
    dac_byte_reg u_l0 (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_en(wr_l0),
        .wr_data(sfr_wdata),
        .value_q(channel0_low_byte)
    ); // see RQ11
    dac_byte_reg u_h0 (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_en(wr_h0),
        .wr_data(sfr_wdata),
        .value_q(channel0_high_byte)
    );
    dac_byte_reg u_l1 (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_en(wr_l1),
        .wr_data(sfr_wdata),
        .value_q(channel1_low_byte)
    );
    dac_byte_reg u_h1 (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_en(wr_h1),
        .wr_data(sfr_wdata),
        .value_q(channel1_high_byte)
    );

    // ------------------------------------------------------------
    // Code formation
    // ------------------------------------------------------------
    // The low byte is taken from the bus in the cycle it is written, so the applied code already
    // contains it; the high byte must be in place beforehand, which is why software writes it first.
    logic [7:0] low0_now;
    logic [7:0] low1_now;
    logic [CODE_W-1:0] next0;
    logic [CODE_W-1:0] next1;

    assign low0_now = wr_l0 ? sfr_wdata : channel0_low_byte;
    assign low1_now = wr_l1 ? sfr_wdata : channel1_low_byte;
    // In 8-bit mode the high byte plays no part.
    assign next0 = form_code(eight_bit_mode, low0_now, channel0_high_byte); // see RQ13 see RQ1 see RQ9
    assign next1 = form_code(eight_bit_mode, low1_now, channel1_high_byte); // see RQ13 see RQ1 see RQ9

    logic [CODE_W-1:0] held0;
    logic [CODE_W-1:0] held1;

    dac_channel_update u_upd0 (
        .sys_clk(sys_clk),
        .reset(reset),
        .low_written(wr_l0),
        .sync_rise(sync_rise),
        .sync_mode(sync_mode),
        .next_code(next0),
        .code_q(held0),
        .pending(ch0_pending)
    ); // see RQ7
    dac_channel_update u_upd1 (
        .sys_clk(sys_clk),
        .reset(reset),
        .low_written(wr_l1),
        .sync_rise(sync_rise),
        .sync_mode(sync_mode),
        .next_code(next1),
        .code_q(held1),
        .pending(ch1_pending)
    ); // see RQ7

    // ------------------------------------------------------------
    // Analog-side outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ch0_code <= CODE_ZERO;
            ch1_code <= CODE_ZERO;
            span_select_ch0 <= 1'b0;
            span_select_ch1 <= 1'b0;
            ch0_power <= 1'b0;
            ch1_power <= 1'b0;
            ch0_output_enable <= 1'b0;
            ch1_output_enable <= 1'b0;
        end else begin
            ch0_code <= zero_force_n_ch0 ? held0 : CODE_ZERO; // see RQ5
            ch1_code <= zero_force_n_ch1 ? held1 : CODE_ZERO; // see RQ5
            span_select_ch0 <= converter_output_control_q[BIT_SPAN_CH0]; // see RQ4
            span_select_ch1 <= converter_output_control_q[BIT_SPAN_CH1]; // see RQ3
            ch0_power <= power_on_ch0; // see RQ6
            ch1_power <= power_on_ch1; // see RQ6
            ch0_output_enable <= power_on_ch0; // see RQ12
            ch1_output_enable <= power_on_ch1; // see RQ12
        end
    end

    // ------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                ADDR_CH0_LOW: sfr_rdata <= channel0_low_byte;
                ADDR_CH0_HIGH: sfr_rdata <= channel0_high_byte;
                ADDR_CH1_LOW: sfr_rdata <= channel1_low_byte;
                ADDR_CH1_HIGH: sfr_rdata <= channel1_high_byte;
                ADDR_CONTROL: sfr_rdata <= converter_output_control_q;
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

endmodule

/* File: dual_dac_register_control_asserts.sv */
// Port-level checker for the dual converter register control block.
module dual_dac_register_control_asserts
    import dac_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Register access
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_sel,
    // Channels
    input wire logic [dac_ctrl_pkg::CODE_W-1:0] ch0_code,
    input wire logic span_select_ch0,
    input wire logic ch0_output_enable,
    input wire logic ch0_power,
    input wire logic [dac_ctrl_pkg::CODE_W-1:0] ch1_code,
    input wire logic span_select_ch1,
    input wire logic ch1_output_enable,
    input wire logic ch1_power,
    input wire logic ch0_pending,
    input wire logic ch1_pending
);
    import dac_ctrl_pkg::*;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // Shadow of the control register
    // ------------------------------------------------------------
    // Outputs lag the register by one edge, so a delayed copy is kept as well.
    logic [7:0] shadow_ctrl_q;
    logic [7:0] ctrl_seen_q;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            shadow_ctrl_q <= CONTROL_RESET;
        end else if (sfr_wr && sfr_addr == ADDR_CONTROL) begin
            shadow_ctrl_q <= sfr_wdata;
        end
    end
    always_ff @(posedge sys_clk) begin
        ctrl_seen_q <= reset ? CONTROL_RESET : shadow_ctrl_q;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_ctrl_follow: assert property (
        span_select_ch0 == ctrl_seen_q[5] && span_select_ch1 == ctrl_seen_q[6] && ch0_power == ctrl_seen_q[0]
        && ch1_power == ctrl_seen_q[1]) else $error("control outputs differ from control register");
    chk_enable_power: assert property (
        ch0_output_enable == ch0_power && ch1_output_enable == ch1_power) else $error("output enable wrong");
    chk_reset_state: assert property ($fell(reset) |-> ch0_code == 12'h000 && ch1_code == 12'h000
        && !ch0_pending && !ch1_pending && sfr_rdata == 8'h00) else $error("bad state after reset");
    chk_unmapped_read: assert property (sfr_rd && !sfr_sel |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_eight_bit: assert property (
        sfr_wr && sfr_addr == ADDR_CH0_LOW && shadow_ctrl_q[7] && shadow_ctrl_q[2] && shadow_ctrl_q[3]
        |-> ##2 ch0_code == {$past(sfr_wdata, 2), 4'h0}) else $error("8-bit immediate load wrong");
    chk_twelve_bit: assert property (
        sfr_wr && sfr_addr == ADDR_CH1_LOW && !shadow_ctrl_q[7] && shadow_ctrl_q[2] && shadow_ctrl_q[4]
        |-> ##2 ch1_code[7:0] == $past(sfr_wdata, 2)) else $error("12-bit immediate load wrong");
    chk_held_write: assert property (
        sfr_wr && sfr_addr == ADDR_CH1_LOW && !shadow_ctrl_q[2] |=> ch1_pending) else $error("held write lost");
    chk_sync_release: assert property (
        sfr_wr && sfr_addr == ADDR_CONTROL && !shadow_ctrl_q[2] && sfr_wdata[2]
        |-> ##2 !ch0_pending && !ch1_pending) else $error("sync rise did not release");
    chk_zero_force: assert property (!shadow_ctrl_q[4] |=> ch1_code == 12'h000)
        else $error("cleared channel not zero");
    chk_high_quiet: assert property (sfr_wr && sfr_addr == ADDR_CH0_HIGH |=> ##1 $stable(ch0_code))
        else $error("high byte write moved output");
endmodule

bind dual_dac_register_control dual_dac_register_control_asserts u_asserts (.sys_clk(sys_clk), .reset(reset),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sfr_sel(sfr_sel), .ch0_code(ch0_code), .span_select_ch0(span_select_ch0),
    .ch0_output_enable(ch0_output_enable), .ch0_power(ch0_power), .ch1_code(ch1_code),
    .span_select_ch1(span_select_ch1), .ch1_output_enable(ch1_output_enable), .ch1_power(ch1_power),
    .ch0_pending(ch0_pending), .ch1_pending(ch1_pending));

/* File: dual_dac_register_control_test.sv */
// Self-checking testbench for the dual converter register control block.
module dual_dac_register_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dac_ctrl_pkg::*;

    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata, ctrl, lo0, hi0, lo1, hi1;
    logic sfr_sel, span_select_ch0, span_select_ch1, ch0_output_enable, ch1_output_enable;
    logic ch0_power, ch1_power, ch0_pending, ch1_pending;
    logic [CODE_W-1:0] ch0_code, ch1_code;
    logic [CODE_W-1:0] exp0 = 12'h000;
    logic [CODE_W-1:0] exp1 = 12'h000;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h4118;
    logic rd_pend = 1'b0;
    int mismatches = 0;
    int cmp_count = 0;

    dual_dac_register_control u_dual_dac_register_control (.sys_clk(sys_clk), .reset(reset),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_sel(sfr_sel), .ch0_code(ch0_code), .span_select_ch0(span_select_ch0),
        .ch0_output_enable(ch0_output_enable), .ch0_power(ch0_power), .ch1_code(ch1_code),
        .span_select_ch1(span_select_ch1), .ch1_output_enable(ch1_output_enable), .ch1_power(ch1_power),
        .ch0_pending(ch0_pending), .ch1_pending(ch1_pending));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] expect_v);
        cmp_count++;
        if (seen !== expect_v) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expect_v);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge sys_clk);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
    endtask

    // Leaves room for the two-edge load path before outputs are sampled.
    task automatic codes(input logic [11:0] e0, input logic [11:0] e1);
        repeat (3) @(posedge sys_clk);
        #1;
        check(ch0_code, e0);
        check(ch1_code, e1);
    endtask

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Read data shows one edge after the read is taken.
    always @(posedge sys_clk) begin
        if (rd_pend && exp_q.size() > 0) begin
            check(sfr_rdata, exp_q.pop_front());
        end
        rd_pend = sfr_rd;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        close_out();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        rd(ADDR_CONTROL, CONTROL_RESET);
        for (int a = int'(ADDR_CH0_LOW); a <= int'(ADDR_CH1_HIGH); a++) begin
            rd(8'(a), DATA_RESET);
        end
        rd(8'hf8, 8'h00);
        check(sfr_sel, 1'b0);
        codes(12'h000, 12'h000);
        check({ch1_power, ch0_power, ch1_output_enable, ch0_output_enable}, 4'h0);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            ctrl = {seed[7:5], 5'h1f};
            hi0 = seed[15:8];
            lo0 = seed[23:16];
            hi1 = seed[31:24];
            lo1 = seed[11:4];
            wr(ADDR_CONTROL, ctrl);
            wr(ADDR_CH0_HIGH, hi0);
            wr(ADDR_CH1_HIGH, hi1);
            codes(exp0, exp1);
            check({span_select_ch1, span_select_ch0, ch1_power, ch0_power}, {ctrl[6:5], 2'b11});
            wr(ADDR_CH0_LOW, lo0);
            wr(ADDR_CH1_LOW, lo1);
            exp0 = ctrl[7] ? {lo0, 4'h0} : {hi0[3:0], lo0};
            exp1 = ctrl[7] ? {lo1, 4'h0} : {hi1[3:0], lo1};
            codes(exp0, exp1);
            rd(ADDR_CH1_HIGH, hi1);
        end
        wr(ADDR_CONTROL, 8'h1b);
        lo0 = 8'h5a;
        lo1 = 8'ha5;
        wr(ADDR_CH0_LOW, lo0);
        wr(ADDR_CH1_LOW, lo1);
        codes(exp0, exp1);
        check({ch1_pending, ch0_pending}, 2'b11);
        wr(ADDR_CONTROL, 8'h1f);
        exp0 = {hi0[3:0], lo0};
        exp1 = {hi1[3:0], lo1};
        codes(exp0, exp1);
        check({ch1_pending, ch0_pending}, 2'b00);
        wr(ADDR_CONTROL, 8'h07);
        codes(12'h000, 12'h000);
        wr(ADDR_CONTROL, 8'h0f);
        codes(exp0, 12'h000);
        wr(ADDR_CONTROL, 8'h1c);
        codes(exp0, exp1);
        check({ch1_output_enable, ch0_output_enable, ch1_power, ch0_power}, 4'h0);
        rd(ADDR_CONTROL, 8'h1c);
        check(sfr_sel, 1'b1);
        repeat (2) @(posedge sys_clk);
        close_out();
    end
endmodule
